// ---- pkg/stc_pkg.sv ----
// constants and register map of the sixteen bit timer counter
// Contract
// - count 0000h to ffffh, then wrap to zero
// - wrap sets flag bit 0; enable gates interrupt
// - clock select: external rising edges or fosc/4
// - run bit set counts, cleared halts
// - divide select 11/10/01/00 gives 8/4/2/1
// - oscillator enable turns low power oscillator on
// - counter source: osc input pin or clock pin
// - oscillator enabled forces both pins to inputs
// - sync bit picks synchronised mode, ignored internally
// - first falling edge needed before rising edges count
// - prescaler before synchroniser in synchronised mode
// - sleep, synchronised: count holds, prescaler runs
// - unsynchronised mode counts in sleep, can wake
// - unsynchronised count is no capture/compare timebase
// - count byte reads always return clean bytes
// - capture/compare unit can reset the count
// - write beats capture/compare reset; reset sets no flag
// - count byte write clears the prescaler
// - reset zeroes control, flag and enable, never the count
package stc_pkg;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int unsigned CLK_HZ    = 25_000_000;
    // oscillator periods per instruction cycle
    localparam int unsigned INSTR_DIV = 4;

    // --------------------------------------------------------------
    // register map, byte addresses on the bus
    // --------------------------------------------------------------
    localparam int unsigned ADR_W      = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h10;
    localparam logic [7:0]  OFF_CNT_LO = 8'h14;
    localparam logic [7:0]  OFF_CNT_HI = 8'h18;
    localparam logic [7:0]  OFF_FLAG   = 8'h1c;
    localparam logic [7:0]  OFF_IRQ_EN = 8'h20;

    // --------------------------------------------------------------
    // timer_control fields
    // --------------------------------------------------------------
    localparam int unsigned CTRL_RUN_BIT      = 0;
    localparam int unsigned CTRL_CS_BIT       = 1;
    localparam int unsigned CTRL_SYNC_DIS_BIT = 2;
    localparam int unsigned CTRL_OSC_EN_BIT   = 3;
    localparam int unsigned CTRL_DIV_LSB      = 4;
    localparam int unsigned CTRL_DIV_MSB      = 5;
    localparam int unsigned CTRL_W            = 6;
    localparam logic [5:0]  CTRL_RESET        = 6'h00;

    // --------------------------------------------------------------
    // flag and enable registers, count limits
    // --------------------------------------------------------------
    localparam int unsigned FLAG_WRAP_BIT = 0;
    localparam logic        FLAG_RESET    = 1'b0;
    localparam logic        IRQ_EN_RESET  = 1'b0;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hffff;
    localparam int unsigned PSC_W         = 3;

endpackage

// ---- verilog/stc_prescaler.sv ----
// input prescaler of the timer counter, divide by 1, 2, 4 or 8
module stc_prescaler #(
    parameter int unsigned PSC_W = stc_pkg::PSC_W
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       clear_i,
    input  wire logic [1:0] div_sel_i,
    output logic            tick_o
);

    logic [PSC_W-1:0] cnt_q;
    logic [PSC_W-1:0] terminal;
    logic             tick_q;

    if (PSC_W < 3)
    begin : g_check
        $error("prescaler needs at least three bits for divide by eight");
    end

    // --------------------------------------------------------------
    // ripple count, terminal value follows divide select
    // --------------------------------------------------------------
    assign terminal = PSC_W'((4'h1 << div_sel_i) - 4'h1);

    always_ff @(posedge clk_i)
    begin
        if (rst_i || clear_i)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (tick_i)
        begin
            if (cnt_q >= terminal)
            begin
                cnt_q  <= '0;
                tick_q <= 1'b1;
            end
            else
            begin
                cnt_q  <= cnt_q + PSC_W'(1);
                tick_q <= 1'b0;
            end
        end
        else
        begin
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_presc_clear: assert property (clear_i |=> cnt_q == '0 && !tick_o)
        else $error("prescaler not cleared");
    chk_div_one: assert property (div_sel_i == 2'b00 && tick_i && !clear_i |=> tick_o)
        else $error("divide by one lost a tick");
    chk_div_eight: assert property (div_sel_i == 2'b11 && tick_i && !clear_i && cnt_q == '0
                                    |=> !tick_o)
        else $error("divide by eight ticked early");

endmodule

// ---- verilog/stc_timer.sv ----
// sixteen bit timer counter with wishbone register slave
module stc_timer (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [stc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    input  wire logic                      sleep_i,
    input  wire logic                      ccp_reset_i,
    input  wire logic [1:0]                pin_in_i,
    input  wire logic [1:0]                port_out_i,
    input  wire logic [1:0]                port_dir_i,
    output logic      [1:0]                pin_out_o,
    output logic      [1:0]                pin_oe_o,
    output logic                           osc_amp_en_o,
    output logic      [15:0]               count_o,
    output logic                           timebase_valid_o,
    output logic                           irq_o,
    output logic                           wake_o
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [stc_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0]                count_q;
    logic                       flag_q;
    logic                       en_q;
    logic                       irq_q;
    logic                       wake_q;
    logic                       timebase_q;
    logic [1:0]                 pin_out_q;
    logic [1:0]                 pin_oe_q;
    logic                       osc_amp_q;
    logic                       ack_q;
    logic [31:0]                dat_q;
    logic [1:0]                 instr_cnt_q;
    logic                       instr_tick_q;
    logic                       src_q;
    logic                       armed_q;
    logic                       sync_a_q;
    logic                       sync_b_q;

    // --------------------------------------------------------------
    // decoded controls and strobes
    // --------------------------------------------------------------
    logic        run;
    logic        cs;
    logic        sync_dis;
    logic        osc_en;
    logic [1:0]  div_sel;
    logic        req;
    logic        commit;
    logic        wr_en;
    logic        wr_ctrl;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_cnt;
    logic        wr_flag;
    logic        wr_irq_en;
    logic        src;
    logic        rise;
    logic        fall;
    logic        ext_edge;
    logic        psc_in;
    logic        psc_tick;
    logic        inc;
    logic        wrap;
    logic [31:0] rdata;

    assign run      = ctrl_q[stc_pkg::CTRL_RUN_BIT];
    assign cs       = ctrl_q[stc_pkg::CTRL_CS_BIT];
    assign sync_dis = ctrl_q[stc_pkg::CTRL_SYNC_DIS_BIT];
    assign osc_en   = ctrl_q[stc_pkg::CTRL_OSC_EN_BIT];
    assign div_sel  = ctrl_q[stc_pkg::CTRL_DIV_MSB:stc_pkg::CTRL_DIV_LSB];

    // --------------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, write at ack
    // --------------------------------------------------------------
    assign req       = wb_cyc_i && wb_stb_i;
    assign commit    = req && ack_q;
    assign wr_en     = commit && wb_we_i && wb_sel_i[0];
    assign wr_ctrl   = wr_en && (wb_adr_i == stc_pkg::OFF_CTRL);
    assign wr_lo     = wr_en && (wb_adr_i == stc_pkg::OFF_CNT_LO);
    assign wr_hi     = wr_en && (wb_adr_i == stc_pkg::OFF_CNT_HI);
    assign wr_flag   = wr_en && (wb_adr_i == stc_pkg::OFF_FLAG);
    assign wr_irq_en = wr_en && (wb_adr_i == stc_pkg::OFF_IRQ_EN);
    assign wr_cnt    = wr_lo || wr_hi;

    // count bytes come straight from one clocked register, never torn
    always_comb
    begin
        rdata = 32'h0000_0000;
        if (wb_adr_i == stc_pkg::OFF_CTRL)
        begin
            rdata[stc_pkg::CTRL_W-1:0] = ctrl_q;
        end
        else if (wb_adr_i == stc_pkg::OFF_CNT_LO)
        begin
            rdata[7:0] = count_q[7:0];
        end
        else if (wb_adr_i == stc_pkg::OFF_CNT_HI)
        begin
            rdata[7:0] = count_q[15:8];
        end
        else if (wb_adr_i == stc_pkg::OFF_FLAG)
        begin
            rdata[stc_pkg::FLAG_WRAP_BIT] = flag_q;
        end
        else if (wb_adr_i == stc_pkg::OFF_IRQ_EN)
        begin
            rdata[stc_pkg::FLAG_WRAP_BIT] = en_q;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= req && !ack_q;
            if (req && !ack_q)
            begin
                dat_q <= rdata;
            end
        end
    end

    // --------------------------------------------------------------
    // control register, cleared by rst_i whenever it is asserted
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= stc_pkg::CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= wb_dat_i[stc_pkg::CTRL_W-1:0];
        end
    end

    // --------------------------------------------------------------
    // instruction cycle tick, a quarter of the clock
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            instr_cnt_q  <= 2'h0;
            instr_tick_q <= 1'b0;
        end
        else
        begin
            instr_cnt_q  <= instr_cnt_q + 2'h1;
            instr_tick_q <= (instr_cnt_q == 2'(stc_pkg::INSTR_DIV - 1));
        end
    end

    // --------------------------------------------------------------
    // external edge source and falling edge arming
    // --------------------------------------------------------------
    assign src  = osc_en ? pin_in_i[1] : pin_in_i[0];
    assign rise = src && !src_q;
    assign fall = !src && src_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_q   <= 1'b0;
            armed_q <= 1'b0;
        end
        else
        begin
            src_q <= src;
            // re-armed from scratch each time counting restarts
            if (!run || !cs)
            begin
                armed_q <= 1'b0;
            end
            else if (fall)
            begin
                armed_q <= 1'b1;
            end
        end
    end

    assign ext_edge = run && cs && armed_q && rise;
    // the internal clock stops in sleep; external edges keep coming
    assign psc_in   = cs ? ext_edge : (run && instr_tick_q && !sleep_i);

    stc_prescaler #(
        .PSC_W     (stc_pkg::PSC_W)
    ) u_prescaler (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .tick_i    (psc_in),
        .clear_i   (wr_cnt),
        .div_sel_i (div_sel),
        .tick_o    (psc_tick)
    );

    // --------------------------------------------------------------
    // synchroniser after the prescaler, its output ignored in sleep
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_a_q <= 1'b0;
            sync_b_q <= 1'b0;
        end
        else
        begin
            sync_a_q <= psc_tick;
            sync_b_q <= sync_a_q;
        end
    end

    always_comb
    begin
        if (!cs || sync_dis)
        begin
            inc = run && psc_tick;
        end
        else
        begin
            inc = run && sync_b_q && !sleep_i;
        end
    end

    // --------------------------------------------------------------
    // count: write beats ccp reset beats increment; rst_i never clears it
    // --------------------------------------------------------------
    assign wrap = inc && !wr_cnt && !ccp_reset_i && (count_q == stc_pkg::COUNT_MAX);

    always_ff @(posedge clk_i)
    begin
        if (wr_lo)
        begin
            count_q[7:0] <= wb_dat_i[7:0];
        end
        else if (wr_hi)
        begin
            count_q[15:8] <= wb_dat_i[7:0];
        end
        else if (ccp_reset_i)
        begin
            count_q <= stc_pkg::COUNT_ZERO;
        end
        else if (inc)
        begin
            count_q <= count_q + 16'h0001;
        end
    end

    // --------------------------------------------------------------
    // wrap flag and interrupt; a wrap beats a clearing write
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flag_q <= stc_pkg::FLAG_RESET;
            en_q   <= stc_pkg::IRQ_EN_RESET;
        end
        else
        begin
            if (wrap)
            begin
                flag_q <= 1'b1;
            end
            else if (wr_flag)
            begin
                flag_q <= wb_dat_i[stc_pkg::FLAG_WRAP_BIT];
            end
            if (wr_irq_en)
            begin
                en_q <= wb_dat_i[stc_pkg::FLAG_WRAP_BIT];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_q      <= 1'b0;
            wake_q     <= 1'b0;
            timebase_q <= 1'b0;
        end
        else
        begin
            irq_q      <= flag_q && en_q;
            wake_q     <= flag_q && en_q && sleep_i;
            timebase_q <= run && !(cs && sync_dis);
        end
    end

    // --------------------------------------------------------------
    // pins: oscillator takes both pins over as inputs
    // --------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_out_q <= 2'b00;
            pin_oe_q  <= 2'b00;
            osc_amp_q <= 1'b0;
        end
        else
        begin
            pin_out_q <= port_out_i;
            pin_oe_q  <= osc_en ? 2'b00 : ~port_dir_i;
            osc_amp_q <= osc_en;
        end
    end

    assign wb_dat_o         = dat_q;
    assign wb_ack_o         = ack_q;
    assign count_o          = count_q;
    assign irq_o            = irq_q;
    assign wake_o           = wake_q;
    assign timebase_valid_o = timebase_q;
    assign pin_out_o        = pin_out_q;
    assign pin_oe_o         = pin_oe_q;
    assign osc_amp_en_o     = osc_amp_q;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_tick_gap;
        !instr_tick_q [*3] ##1 instr_tick_q;
    endsequence

    sequence s_wrap_cause;
        inc && !wr_cnt && !ccp_reset_i && count_q == stc_pkg::COUNT_MAX;
    endsequence

    chk_wrap_zero: assert property (s_wrap_cause |=> count_q == stc_pkg::COUNT_ZERO)
        else $error("count did not wrap to zero");
    chk_flag_set: assert property (s_wrap_cause |=> flag_q ##1 irq_o == en_q)
        else $error("wrap flag or interrupt wrong after wrap");
    chk_flag_hold: assert property (flag_q && !wr_flag |=> flag_q)
        else $error("wrap flag dropped without a write");
    chk_instr_tick: assert property (instr_tick_q |=> s_tick_gap)
        else $error("instruction tick not every fourth cycle");
    chk_run_halt: assert property (!run && !wr_cnt && !ccp_reset_i |=> $stable(count_q))
        else $error("count moved while halted");
    chk_pins_input: assert property (osc_en |=> pin_oe_o == 2'b00)
        else $error("pin driven while oscillator enabled");
    chk_arm_fall: assert property ($rose(armed_q) |-> $past(fall))
        else $error("armed without a falling edge");
    chk_sleep_hold: assert property (sleep_i && cs && !sync_dis && !wr_cnt && !ccp_reset_i
                                     |=> $stable(count_q))
        else $error("synchronised count moved in sleep");
    chk_wake_out: assert property (flag_q && en_q && sleep_i |=> wake_o)
        else $error("no wake on enabled flag in sleep");
    chk_timebase_off: assert property (cs && sync_dis |=> !timebase_valid_o)
        else $error("unsynchronised count offered as timebase");
    chk_ccp_clear: assert property (ccp_reset_i && !wr_cnt |=> count_q == stc_pkg::COUNT_ZERO)
        else $error("capture compare reset ignored");
    chk_write_wins: assert property (wr_lo && ccp_reset_i
                                     |=> count_q[7:0] == $past(wb_dat_i[7:0]))
        else $error("reset beat a count write");
    chk_ccp_noflag: assert property (ccp_reset_i && !flag_q && !wr_flag |=> !flag_q)
        else $error("capture compare reset set the flag");

endmodule

// ---- verification/stc_clk_src.sv ----
// external clock source model driving the two timer pins
module stc_clk_src (
    input  wire logic       clk_i,
    output logic      [1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pin_o = 2'b11;

    // parked at its idle level between bursts, so it never runs free
    task automatic burst(input int n, input int sel, input logic idle);
        @(posedge clk_i);
        pin_o[sel] <= idle;
        repeat (8) @(posedge clk_i);
        for (int i = 0; i < n; i++)
        begin
            pin_o[sel] <= ~idle;
            repeat (4) @(posedge clk_i);
            pin_o[sel] <= idle;
            repeat (4) @(posedge clk_i);
        end
    endtask
endmodule

// ---- verification/tb_top.sv ----
// self-checking bench of the sixteen bit timer counter
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    localparam logic [7:0] A_CTL = stc_pkg::OFF_CTRL;
    localparam logic [7:0] A_LO  = stc_pkg::OFF_CNT_LO;
    localparam logic [7:0] A_HI  = stc_pkg::OFF_CNT_HI;
    localparam logic [7:0] A_FLG = stc_pkg::OFF_FLAG;
    localparam logic [7:0] A_IEN = stc_pkg::OFF_IRQ_EN;

    logic        clk_i       = 1'b0;
    logic        rst_i       = 1'b1;
    logic        wb_cyc_i    = 1'b0;
    logic        wb_stb_i    = 1'b0;
    logic        wb_we_i     = 1'b0;
    logic [7:0]  wb_adr_i    = 8'h00;
    logic [3:0]  wb_sel_i    = 4'h0;
    logic [31:0] wb_dat_i    = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        sleep_i     = 1'b0;
    // capture/compare clear stands with reset, so the count is known from the start
    logic        ccp_reset_i = 1'b1;
    logic [1:0]  pin_in_i;
    logic [1:0]  port_out_i  = 2'b00;
    logic [1:0]  port_dir_i  = 2'b11;
    logic [1:0]  pin_out_o;
    logic [1:0]  pin_oe_o;
    logic        osc_amp_en_o;
    logic [15:0] count_o;
    logic        timebase_valid_o;
    logic        irq_o;
    logic        wake_o;
    logic [7:0]  exp_q[$];
    int          fail_count  = 0;
    int          check_count = 0;
    logic [15:0] v;

    always #20 clk_i = ~clk_i;

    stc_timer dut (
        .clk_i,
        .rst_i,
        .wb_cyc_i,
        .wb_stb_i,
        .wb_we_i,
        .wb_adr_i,
        .wb_sel_i,
        .wb_dat_i,
        .wb_dat_o,
        .wb_ack_o,
        .sleep_i,
        .ccp_reset_i,
        .pin_in_i,
        .port_out_i,
        .port_dir_i,
        .pin_out_o,
        .pin_oe_o,
        .osc_amp_en_o,
        .count_o,
        .timebase_valid_o,
        .irq_o,
        .wake_o
    );

    stc_clk_src src (
        .clk_i (clk_i),
        .pin_o (pin_in_i)
    );

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // c raises the count reset in the ack cycle, so it meets the write commit
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic c);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
            if (c)
            begin
                ccp_reset_i <= (n == 1);
            end
        end while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 8'h00, 1'b0);
    endtask

    task automatic cnt(input logic [15:0] c);
        wr(A_LO, c[7:0]);
        wr(A_HI, c[15:8]);
    endtask

    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
            chk({8'h00, exp_q.pop_front()}, wb_dat_o[15:0]);

    initial
    begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial
    begin
        void'($urandom(24));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        ccp_reset_i <= 1'b0;
        rd(A_CTL, 8'h00);
        rd(A_FLG, 8'h00);
        rd(A_IEN, 8'h00);
        rd(8'h04, 8'h00);
        port_dir_i <= 2'($urandom);
        port_out_i <= 2'($urandom);
        repeat (3) @(posedge clk_i);
        chk({14'h0, ~port_dir_i}, {14'h0, pin_oe_o});
        chk({14'h0, port_out_i}, {14'h0, pin_out_o});
        // nine pulses leave a prescaler residue at divide by 2, 4 and 8 that the next count write must clear
        for (int d = 0; d < 4; d++)
        begin
            wr(A_CTL, 8'(d << 4) | 8'h03);
            cnt(16'h0010);
            src.burst(9, 0, 1'b1);
            rd(A_LO, 8'h10 + 8'(9 >> d));
        end
        wr(A_CTL, 8'h00);
        src.burst(0, 0, 1'b0);
        wr(A_CTL, 8'h03);
        cnt(16'h0020);
        src.burst(3, 0, 1'b0);
        rd(A_LO, 8'h22);
        src.burst(0, 0, 1'b1);
        wr(A_IEN, 8'h01);
        cnt(16'hfffe);
        src.burst(2, 0, 1'b1);
        rd(A_HI, 8'h00);
        rd(A_FLG, 8'h01);
        chk(16'h0003, {14'h0, irq_o, timebase_valid_o});
        wr(A_FLG, 8'h00);
        rd(A_LO, 8'h00);
        chk(16'h0000, {15'h0, irq_o});
        wr(A_CTL, 8'h13);
        cnt(16'h0100);
        sleep_i <= 1'b1;
        src.burst(3, 0, 1'b1);
        chk(16'h0100, count_o);
        sleep_i <= 1'b0;
        src.burst(1, 0, 1'b1);
        rd(A_LO, 8'h01);
        wr(A_CTL, 8'h06);
        cnt(16'hfffd);
        wr(A_CTL, 8'h07);
        sleep_i <= 1'b1;
        src.burst(3, 0, 1'b1);
        repeat (3) @(posedge clk_i);
        chk(16'h0000, count_o);
        chk(16'h0002, {14'h0, wake_o, timebase_valid_o});
        sleep_i <= 1'b0;
        wr(A_FLG, 8'h00);
        wr(A_CTL, 8'h0b);
        repeat (20) @(posedge clk_i);
        chk(16'h0001, {13'h0, pin_oe_o, osc_amp_en_o});
        cnt(16'h0030);
        src.burst(2, 0, 1'b1);
        src.burst(3, 1, 1'b1);
        rd(A_LO, 8'h33);
        wr(A_CTL, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(16'h0000, {15'h0, osc_amp_en_o});
        cnt(16'h1234);
        ccp_reset_i <= 1'b1;
        @(posedge clk_i);
        ccp_reset_i <= 1'b0;
        rd(A_HI, 8'h00);
        rd(A_FLG, 8'h00);
        xfer(1'b1, A_LO, 8'h55, 1'b1);
        rd(A_LO, 8'h55);
        // the instruction tick phase is free, so allow a small window
        wr(A_CTL, 8'h05);
        cnt(16'h0000);
        repeat (400) @(posedge clk_i);
        wr(A_CTL, 8'h04);
        // the halting write committed at the last edge of wr; wait one edge so its last increment is seen
        @(posedge clk_i);
        v = count_o;
        chk(16'h0001, {15'h0, v >= 16'h0063 && v <= 16'h0067});
        repeat (40) @(posedge clk_i);
        chk(v, count_o);
        // a reset while halted clears the control register but keeps the count
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(A_CTL, 8'h00);
        rd(A_LO, v[7:0]);
        rd(A_HI, v[15:8]);
        tally_and_finish();
    end
endmodule
